// File: rtl/pss_pkg.sv
package pss_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned TICK_DIV_W = 16;

  // Clear-pulse windows in milliseconds
  localparam int unsigned CLR_MIN_SHORT_MS = 100;
  localparam int unsigned CLR_MIN_LONG_MS = 350;
  localparam int unsigned CLR_MAX_MS = 30000;
  localparam int unsigned MS_CNT_W = 15;

  // Interlock policy codes
  localparam logic [2:0] POL_NONE = 3'h1;
  localparam logic [2:0] POL_ALWAYS = 3'h2;
  localparam logic [2:0] POL_START_OR_PERMIT = 3'h3;
  localparam logic [2:0] POL_TDC_OR_PERMIT = 3'h4;

  // Register map, byte addresses
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // Config field layout
  localparam int unsigned CFG_POL_LSB = 0;
  localparam int unsigned CFG_START_EN_BIT = 4;
  localparam int unsigned CFG_STROKE_EN_BIT = 5;
  localparam int unsigned CFG_LONG_PULSE_BIT = 6;
  localparam logic [31:0] CFG_RESET = 32'h0000_0002;
  localparam logic [31:0] CFG_WMASK = 32'h0000_0077;

  // Status field layout
  localparam int unsigned ST_PERMIT_BIT = 0;
  localparam int unsigned ST_PENDING_BIT = 1;
  localparam int unsigned ST_LATCHED_BIT = 2;
  localparam int unsigned ST_PRIM_INV_BIT = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/pss_clear_timer.sv
`timescale 1ns/100ps
// Measures interlock_clear high phase, pulses valid on an in-window fall
module pss_clear_timer
  import pss_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic clear_in, // Sampled interlock_clear
  input wire logic long_sel, // Select 350 ms minimum
  output logic clear_valid // One-cycle valid sequence pulse
);

  typedef struct packed {
    logic [TICK_DIV_W-1:0] div;
    logic [MS_CNT_W-1:0] ms;
    logic prev;
    logic seen_low;
    logic over;
    logic valid;
  } pss_tmr_t;

  pss_tmr_t st_reg, st_next;

  // Saturating millisecond count of the high phase, check on the fall
  always_comb begin
    logic tick;
    logic [MS_CNT_W-1:0] min_ms;
    tick = 1'b0;
    min_ms = long_sel ? MS_CNT_W'(CLR_MIN_LONG_MS) : MS_CNT_W'(CLR_MIN_SHORT_MS);
    st_next = st_reg;
    st_next.valid = 1'b0;
    st_next.prev = clear_in;
    if (!clear_in) begin
      st_next.seen_low = 1'b1;
      st_next.div = '0;
      st_next.ms = '0;
      st_next.over = 1'b0;
    end else if (st_reg.seen_low) begin
      tick = (st_reg.div == TICK_DIV_W'(TICK_MS_CYCLES - 1));
      st_next.div = tick ? '0 : st_reg.div + 1'b1;
      if (tick) begin
        if (st_reg.ms == MS_CNT_W'(CLR_MAX_MS)) begin
          st_next.over = 1'b1;
        end else begin
          st_next.ms = st_reg.ms + 1'b1;
        end
      end
    end
    // Low-high-low with high phase inside the window
    if (st_reg.prev && !clear_in && st_reg.seen_low && !st_reg.over && st_reg.ms >= min_ms) begin
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clear_valid = st_reg.valid;

endmodule

// File: rtl/pss_press_setup.sv
`timescale 1ns/100ps
module pss_press_setup
  import pss_pkg::*;
(
  input wire logic aclk, // System clock, 50 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic start_stop_request, // Start on rise, stop on fall
  input wire logic primary_permit, // Main permit
  input wire logic start_permit, // Optional start-only permit
  input wire logic top_dead_center, // Optional stroke end
  input wire logic interlock_clear, // Interlock clear input
  output logic press_permit_out, // Press permit
  output logic interlock_pending, // Restart interlock pending
  output logic primary_permit_inverted, // Complement of primary permit
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  typedef struct packed {
    logic [31:0] cfg;
    logic start_prev;
    logic prim_prev;
    logic tdc_prev;
    logic permit;
    logic latched;
    logic pending;
    logic prim_inv;
    logic init_done;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pss_state_t;

  pss_state_t st_reg, st_next;
  logic clear_valid;

  // Byte-lane merge used by the config write
  function automatic logic [31:0] pss_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Clear-pulse timer
  pss_clear_timer u_clear_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear_in(interlock_clear),
    .long_sel(st_reg.cfg[CFG_LONG_PULSE_BIT]),
    .clear_valid(clear_valid)
  );

  // Permit, interlock and bus next-state logic
  always_comb begin
    logic [2:0] pol;
    logic start_en;
    logic stroke_en;
    logic start_rise;
    logic start_fall;
    logic prim_fall;
    logic tdc_rise;
    logic start_ok;
    logic stop_start;
    logic stop_tdc;
    logic stop_prim;
    logic lock_set;
    logic lock_pol;
    logic wr_go;
    pol = st_reg.cfg[CFG_POL_LSB +: 3];
    start_en = st_reg.cfg[CFG_START_EN_BIT];
    stroke_en = st_reg.cfg[CFG_STROKE_EN_BIT];
    st_next = st_reg;
    // Edges between successive samples
    start_rise = start_stop_request && !st_reg.start_prev;
    start_fall = !start_stop_request && st_reg.start_prev;
    prim_fall = !primary_permit && st_reg.prim_prev;
    tdc_rise = stroke_en && top_dead_center && !st_reg.tdc_prev;
    start_ok = !start_en || start_permit;
    st_next.start_prev = start_stop_request;
    st_next.prim_prev = primary_permit;
    st_next.tdc_prev = top_dead_center;
    st_next.init_done = 1'b1;
    // Stops that end a running stroke
    stop_start = st_reg.permit && start_fall;
    stop_tdc = st_reg.permit && tdc_rise;
    stop_prim = st_reg.permit && prim_fall;
    lock_set = 1'b0;
    unique case (pol)
      POL_ALWAYS: lock_set = !st_reg.init_done || stop_start || stop_tdc || stop_prim;
      POL_START_OR_PERMIT: lock_set = !st_reg.init_done || stop_start || stop_prim;
      POL_TDC_OR_PERMIT: lock_set = !st_reg.init_done || stop_tdc || stop_prim;
      default: lock_set = 1'b0;
    endcase
    lock_pol = (pol == POL_ALWAYS) || (pol == POL_START_OR_PERMIT) || (pol == POL_TDC_OR_PERMIT);
    // Latch wins over a simultaneous clear; non-latching policy drops any old latch
    if (lock_set) begin
      st_next.latched = 1'b1;
    end else if (clear_valid) begin
      st_next.latched = 1'b0;
    end
    if (!lock_pol) begin
      st_next.latched = 1'b0;
    end
    // Permit output
    if (!primary_permit || start_fall || tdc_rise) begin
      st_next.permit = 1'b0;
    end else if (!st_reg.permit && start_rise && !st_reg.latched && start_ok && st_reg.init_done) begin
      st_next.permit = 1'b1;
    end
    st_next.pending = st_next.latched && primary_permit && start_ok && pol != POL_NONE;
    st_next.prim_inv = !primary_permit;
    // Write channel: address and data in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    st_next.awready = !st_next.aw_got && !st_reg.bvalid;
    st_next.wready = !st_next.w_got && !st_reg.bvalid;
    wr_go = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    if (wr_go) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.awready = 1'b0;
      st_next.wready = 1'b0;
      if (st_reg.aw_addr == ADDR_CONFIG) begin
        st_next.cfg = pss_merge(st_reg.cfg, st_reg.w_data, st_reg.w_strb) & CFG_WMASK;
        st_next.bresp = RESP_OKAY;
      end else if (st_reg.aw_addr == ADDR_STATUS) begin
        st_next.bresp = RESP_OKAY;
      end else begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Read channel
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      if (s_axi_araddr == ADDR_CONFIG) begin
        st_next.rdata = st_reg.cfg;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        st_next.rdata[ST_PERMIT_BIT] = st_reg.permit;
        st_next.rdata[ST_PENDING_BIT] = st_reg.pending;
        st_next.rdata[ST_LATCHED_BIT] = st_reg.latched;
        st_next.rdata[ST_PRIM_INV_BIT] = st_reg.prim_inv;
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  // State register; start request sampled high at reset needs a fresh rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.cfg <= CFG_RESET;
      st_reg.start_prev <= 1'b1;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign press_permit_out = st_reg.permit;
  assign interlock_pending = st_reg.pending;
  assign primary_permit_inverted = st_reg.prim_inv;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

endmodule

// File: dv/pss_press_setup_props.sv
`timescale 1ns/100ps
// Port-level checks for the press setup block
module pss_press_setup_chk (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic start_stop_request, // Start/stop input
  input wire logic primary_permit, // Main permit
  input wire logic press_permit_out, // Press permit
  input wire logic interlock_pending, // Interlock pending
  input wire logic primary_permit_inverted, // Inverted permit
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready // R ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Press side relations
  AST_INV: assert property ($past(aresetn) |-> primary_permit_inverted == !$past(primary_permit))
    else $error("inverted permit wrong");
  AST_PRIM_LOW: assert property (!primary_permit |=> !press_permit_out)
    else $error("permit high with primary low");
  AST_STOP_FALL: assert property ($fell(start_stop_request) |=> !press_permit_out)
    else $error("permit high after start fall");
  AST_RISE_CAUSE: assert property ($rose(press_permit_out) |->
    $past(start_stop_request) && !$past(start_stop_request, 2) && $past(primary_permit))
    else $error("permit rose without start edge");
  AST_EXCL: assert property (!(press_permit_out && interlock_pending))
    else $error("permit high while pending");
  AST_PEND_PRIM: assert property (interlock_pending |-> $past(primary_permit))
    else $error("pending with primary low");
  // Bus timing
  AST_BRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RVALID: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule
bind pss_press_setup pss_press_setup_chk u_chk (.aclk, .aresetn, .start_stop_request, .primary_permit,
  .press_permit_out, .interlock_pending, .primary_permit_inverted, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);

// File: dv/pss_contact_model.sv
`timescale 1ns/100ps
// Contact monitor stand-in feeding permit and stroke end
module pss_contact_model (
  input wire logic aclk, // Clock
  input wire logic permit_cmd, // Wanted permit level
  input wire logic tdc_cmd, // Wanted stroke-end level
  output logic primary_permit, // Permit to block
  output logic top_dead_center // Stroke end to block
);
  // Registered drive just after each edge
  always_ff @(posedge aclk) begin
    primary_permit <= permit_cmd;
    top_dead_center <= tdc_cmd;
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pss_pkg::*;
  logic aclk, aresetn, start_stop_request, start_permit, interlock_clear, permit_cmd, tdc_cmd;
  logic primary_permit, top_dead_center, press_permit_out, interlock_pending, primary_permit_inverted;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fail_count, cmp_count, cyc;
  pss_press_setup DUT (.aclk, .aresetn, .start_stop_request, .primary_permit, .start_permit, .top_dead_center,
    .interlock_clear, .press_permit_out, .interlock_pending, .primary_permit_inverted, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  pss_contact_model u_mon (.aclk, .permit_cmd, .tdc_cmd, .primary_permit, .top_dead_center);
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write: both items offered, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        done = 1;
        chk(32'(s_axi_bresp), 32'(r));
      end
    end
  endtask
  // Bus read with expected data and response
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        done = 1;
        chk(s_axi_rdata, d);
        chk(32'(s_axi_rresp), 32'(r));
      end
    end
  endtask
  // Press inputs applied, then permit and pending compared
  task automatic step(input logic s, p, t, e, input logic o, q);
    @(posedge aclk);
    start_stop_request <= s;
    permit_cmd <= p;
    tdc_cmd <= t;
    start_permit <= e;
    tick(4);
    chk(32'(press_permit_out), 32'(o));
    chk(32'(interlock_pending), 32'(q));
  endtask
  // Main sequence
  initial begin
    {aresetn, start_stop_request, start_permit, interlock_clear, permit_cmd, tdc_cmd} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {fail_count, cmp_count, cyc} = '0;
    tick(20);
    aresetn <= 1'b1;
    rd(ADDR_CONFIG, CFG_RESET, RESP_OKAY);
    step(0, 1, 0, 0, 0, 1);
    step(1, 1, 0, 0, 0, 1);
    interlock_clear <= 1'b1;
    tick(20);
    interlock_clear <= 1'b0;
    tick(4);
    chk(32'(interlock_pending), 32'h1);
    wr(4'h8, 32'h0, RESP_SLVERR);
    rd(4'hC, 32'h0, RESP_SLVERR);
    wr(ADDR_CONFIG, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ADDR_CONFIG, CFG_WMASK, RESP_OKAY);
    wr(ADDR_CONFIG, 32'h0000_0001, RESP_OKAY);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 1, 0);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 1, 0);
    step(1, 0, 0, 0, 0, 0);
    chk(32'(primary_permit_inverted), 32'h1);
    step(1, 1, 0, 0, 0, 0);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 1, 0);
    step(1, 1, 1, 0, 1, 0);
    wr(ADDR_CONFIG, 32'h0000_0021, RESP_OKAY);
    step(1, 1, 0, 0, 1, 0);
    step(1, 1, 1, 0, 0, 0);
    step(0, 1, 1, 0, 0, 0);
    step(1, 1, 1, 0, 1, 0);
    wr(ADDR_CONFIG, 32'h0000_0011, RESP_OKAY);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 0, 0);
    step(0, 1, 0, 1, 0, 0);
    step(1, 1, 0, 1, 1, 0);
    step(1, 1, 0, 0, 1, 0);
    wr(ADDR_CONFIG, 32'h0000_0001, RESP_OKAY);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 1, 0);
    wr(ADDR_CONFIG, 32'h0000_0023, RESP_OKAY);
    step(1, 1, 1, 0, 0, 0);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 1, 0);
    wr(ADDR_CONFIG, 32'h0000_0024, RESP_OKAY);
    step(0, 1, 0, 0, 0, 0);
    step(1, 1, 0, 0, 1, 0);
    step(1, 1, 1, 0, 0, 1);
    aresetn <= 1'b0;
    tick(5);
    aresetn <= 1'b1;
    step(0, 1, 0, 0, 0, 1);
    rd(ADDR_CONFIG, CFG_RESET, RESP_OKAY);
    end_of_test();
  end
endmodule
